// *** verilog/dmd_pkg.sv ***
// Constants, types and helper functions for the DMA channel mode decoder.
package dmd_pkg;
    localparam int NUM_CH = 4;
    localparam int EXT_CH_LAST = 1;
    localparam logic [7:0] ADDR_CTL0 = 8'h00;
    localparam logic [7:0] ADDR_CTL_LAST = 8'h0C;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam int ADDR_IDX_HI = 3;
    localparam int ADDR_IDX_LO = 2;
    localparam int BIT_DEST_WAIT = 24;
    localparam int RSV_HI = 23;
    localparam int RSV_LO = 20;
    localparam int BIT_SAMPLE = 19;
    localparam int BIT_ACC_POL = 18;
    localparam int BIT_ACK_TIM = 17;
    localparam int BIT_ACK_POL = 16;
    localparam int DM_HI = 15;
    localparam int DM_LO = 14;
    localparam int SM_HI = 13;
    localparam int SM_LO = 12;
    localparam int RS_HI = 11;
    localparam int RS_LO = 8;
    localparam int BIT_BURST = 7;
    localparam int TS_HI = 6;
    localparam int TS_LO = 4;
    localparam int BIT_TE = 1;
    localparam int BIT_DE = 0;
    localparam int BIT_MODE_OD = 0;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTL_WMASK_EXT = 32'hFF0F_FFF5;
    localparam logic [31:0] CTL_WMASK_INT = 32'hFF0A_FFF5;
    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    localparam logic [3:0] RS_EXT_DUAL = 4'h0;
    localparam logic [3:0] RS_EXT_MEM2DEV = 4'h2;
    localparam logic [3:0] RS_EXT_DEV2MEM = 4'h3;
    localparam logic [3:0] RS_AUTO_MM = 4'h4;
    localparam logic [3:0] RS_AUTO_MP = 4'h5;
    localparam logic [3:0] RS_AUTO_PM = 4'h6;
    localparam logic [3:0] RS_SER_TX = 4'h8;
    localparam logic [3:0] RS_SER_RX = 4'h9;
    localparam logic [3:0] RS_FIFO_TX = 4'hA;
    localparam logic [3:0] RS_FIFO_RX = 4'hB;
    localparam logic [3:0] RS_TMR_MM = 4'hC;
    localparam logic [3:0] RS_TMR_MP = 4'hD;
    localparam logic [3:0] RS_TMR_PM = 4'hE;
    localparam logic [2:0] TS_QUAD = 3'h0;
    localparam logic [2:0] TS_BYTE = 3'h1;
    localparam logic [2:0] TS_WORD = 3'h2;
    localparam logic [2:0] TS_LONG = 3'h3;
    localparam logic [2:0] TS_BLOCK = 3'h4;
    localparam logic [7:0] STEP_QUAD = 8'h08;
    localparam logic [7:0] STEP_BYTE = 8'h01;
    localparam logic [7:0] STEP_WORD = 8'h02;
    localparam logic [7:0] STEP_LONG = 8'h04;
    localparam logic [7:0] STEP_BLOCK = 8'h20;
    localparam logic [7:0] STEP_NONE = 8'h00;
    localparam logic [3:0] LOAD_INC_MODES = {AM_INC, AM_INC};

    typedef struct packed {
        logic [3:0][31:0] ctl;
        logic ondemand;
        logic rsp;
        logic [31:0] rdata;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [3:0] req;
        logic [3:0] ack;
        logic [3:0] accepted;
        logic [3:0] area6;
        logic [3:0] burst_level;
        logic [3:0] burst_edge;
        logic [3:0][7:0] dstep;
        logic [3:0][7:0] sstep;
    } dmd_state_t;

    function automatic logic [7:0] dmd_unit(input logic [2:0] ts);
        logic [7:0] u;
        u = STEP_NONE;
        case (ts)
            TS_QUAD: u = STEP_QUAD;
            TS_BYTE: u = STEP_BYTE;
            TS_WORD: u = STEP_WORD;
            TS_LONG: u = STEP_LONG;
            TS_BLOCK: u = STEP_BLOCK;
            default: u = STEP_NONE;
        endcase
        return u;
    endfunction : dmd_unit

    // Signed step; a prohibited code or an ignored field moves nothing.
    function automatic logic [7:0] dmd_step(input logic [1:0] md, input logic [2:0] ts,
                                            input logic ignore);
        logic [7:0] s;
        s = STEP_NONE;
        if (!ignore) begin
            if (md == AM_INC) begin
                s = dmd_unit(ts);
            end else if (md == AM_DEC) begin
                s = STEP_NONE - dmd_unit(ts);
            end
        end
        return s;
    endfunction : dmd_step

    function automatic logic dmd_is_ext(input logic [3:0] rs);
        return (rs == RS_EXT_DUAL) || (rs == RS_EXT_MEM2DEV) || (rs == RS_EXT_DEV2MEM);
    endfunction : dmd_is_ext
endpackage : dmd_pkg

// *** verilog/dmd_channel_decode.sv ***
// Four-channel DMA control register file with request, acknowledge and step decoding.
`timescale 1ns/10ps
module dmd_channel_decode #(
    parameter bit P_OD_ACK_CH0 = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [3:0] i_ext_request_pin_b,
    input wire logic i_serial1_tx_empty,
    input wire logic i_serial1_rx_full,
    input wire logic i_serial2_fifo_tx_empty,
    input wire logic i_serial2_fifo_rx_full,
    input wire logic i_timer2_capture,
    input wire logic [3:0] i_accept,
    input wire logic [3:0] i_chan_busy,
    input wire logic i_read_cycle,
    input wire logic i_write_cycle,
    input wire logic [3:0] i_transfer_end,
    input wire logic i_dtr_load,
    output logic [3:0] o_request,
    output logic [3:0] o_request_accepted_out,
    output logic [3:0] o_ack_out,
    output logic [3:0] o_dest_wait_area6,
    output logic [3:0] o_burst_level,
    output logic [3:0] o_burst_edge,
    output logic [31:0] o_dest_step,
    output logic [31:0] o_src_step,
    output logic o_on_demand_mode
);

    dmd_pkg::dmd_state_t s;
    dmd_pkg::dmd_state_t next_s;

    logic [31:0] be_mask;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic [1:0] wr_idx;
    logic od;
    logic [3:0][3:0] code;
    logic [3:0] ext_ok;
    logic [3:0] edge_sel;
    logic [3:0] pin_req;
    logic [3:0] periph;
    logic [3:0] pol_ok;
    logic [3:0] tim_ok;
    logic [3:0] single;
    logic [3:0] raw_ack;

    assign od = s.ondemand;
    assign wr_idx = i_avs_address[dmd_pkg::ADDR_IDX_HI:dmd_pkg::ADDR_IDX_LO];
    assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // Every access costs exactly one wait cycle so read data always come from a flop.
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s.rsp;
    assign o_avs_readdata = s.rdata;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (i_avs_address >= dmd_pkg::ADDR_CTL0 && i_avs_address <= dmd_pkg::ADDR_CTL_LAST) begin
            rd_word = s.ctl[wr_idx];
        end else if (i_avs_address == dmd_pkg::ADDR_MODE) begin
            rd_word[dmd_pkg::BIT_MODE_OD] = s.ondemand;
        end else if (i_avs_address == dmd_pkg::ADDR_STATUS) begin
            rd_word[dmd_pkg::NUM_CH-1:0] = s.req;
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    always_comb begin
        next_s = s;
        wmask = 32'h0000_0000;
        code = '0;
        ext_ok = '0;
        edge_sel = '0;
        pin_req = '0;
        periph = '0;
        pol_ok = '0;
        tim_ok = '0;
        single = '0;
        raw_ack = '0;

        next_s.rsp = (i_avs_read | i_avs_write) & ~s.rsp;
        if (i_avs_read & ~s.rsp) begin
            next_s.rdata = rd_word;
        end

        // Writes land on the cycle where waitrequest is low.
        if (i_avs_write & s.rsp) begin
            if (i_avs_address >= dmd_pkg::ADDR_CTL0 &&
                i_avs_address <= dmd_pkg::ADDR_CTL_LAST) begin
                if (wr_idx <= 2'(dmd_pkg::EXT_CH_LAST)) begin
                    wmask = be_mask & dmd_pkg::CTL_WMASK_EXT;
                end else begin
                    wmask = be_mask & dmd_pkg::CTL_WMASK_INT;
                end
                next_s.ctl[wr_idx] = (s.ctl[wr_idx] & ~wmask) | (i_avs_writedata & wmask);
                // The end flag can only be cleared by software, never set.
                if (i_avs_byteenable[0] && !i_avs_writedata[dmd_pkg::BIT_TE]) begin
                    next_s.ctl[wr_idx][dmd_pkg::BIT_TE] = 1'b0;
                end
            end else if (i_avs_address == dmd_pkg::ADDR_MODE) begin
                if (i_avs_byteenable[0]) begin
                    next_s.ondemand = i_avs_writedata[dmd_pkg::BIT_MODE_OD];
                end
            end
        end

        // Hardware events are applied after the bus write so that the set wins.
        for (int c = 0; c < dmd_pkg::NUM_CH; c++) begin
            if (i_transfer_end[c]) begin
                next_s.ctl[c][dmd_pkg::BIT_TE] = 1'b1;
            end
        end
        if (od && i_dtr_load) begin
            next_s.ctl[0][dmd_pkg::DM_HI:dmd_pkg::SM_LO] = dmd_pkg::LOAD_INC_MODES;
        end

        // Only the second stage and the delayed copy feed the detectors.
        next_s.sync1 = i_ext_request_pin_b;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;

        for (int c = 0; c < dmd_pkg::NUM_CH; c++) begin
            code[c] = s.ctl[c][dmd_pkg::RS_HI:dmd_pkg::RS_LO];
            ext_ok[c] = dmd_pkg::dmd_is_ext(code[c]) && (od || c <= dmd_pkg::EXT_CH_LAST);
            edge_sel[c] = s.ctl[c][dmd_pkg::BIT_SAMPLE] &&
                          (od || c <= dmd_pkg::EXT_CH_LAST);
            if (edge_sel[c]) begin
                pin_req[c] = s.prev[c] & ~s.sync2[c];
            end else begin
                pin_req[c] = ~s.sync2[c];
            end
            case (code[c])
                dmd_pkg::RS_AUTO_MM: periph[c] = 1'b1;
                dmd_pkg::RS_AUTO_MP: periph[c] = 1'b1;
                dmd_pkg::RS_AUTO_PM: periph[c] = 1'b1;
                dmd_pkg::RS_SER_TX: periph[c] = i_serial1_tx_empty;
                dmd_pkg::RS_SER_RX: periph[c] = i_serial1_rx_full;
                dmd_pkg::RS_FIFO_TX: periph[c] = i_serial2_fifo_tx_empty;
                dmd_pkg::RS_FIFO_RX: periph[c] = i_serial2_fifo_rx_full;
                dmd_pkg::RS_TMR_MM: periph[c] = i_timer2_capture;
                dmd_pkg::RS_TMR_MP: periph[c] = i_timer2_capture;
                dmd_pkg::RS_TMR_PM: periph[c] = i_timer2_capture;
                default: periph[c] = 1'b0;
            endcase
            if (s.ctl[c][dmd_pkg::BIT_DE] && !s.ctl[c][dmd_pkg::BIT_TE]) begin
                next_s.req[c] = ext_ok[c] ? pin_req[c] : periph[c];
            end else begin
                next_s.req[c] = 1'b0;
            end

            next_s.burst_level[c] = ext_ok[c] & s.ctl[c][dmd_pkg::BIT_BURST] & ~edge_sel[c];
            next_s.burst_edge[c] = ext_ok[c] & s.ctl[c][dmd_pkg::BIT_BURST] & edge_sel[c];

            pol_ok[c] = !od && c <= dmd_pkg::EXT_CH_LAST;
            next_s.accepted[c] = i_accept[c] ^ (pol_ok[c] & s.ctl[c][dmd_pkg::BIT_ACC_POL]);

            if (od) begin
                tim_ok[c] = (c != 0) || P_OD_ACK_CH0;
            end else begin
                tim_ok[c] = c <= dmd_pkg::EXT_CH_LAST;
            end
            single[c] = (code[c] == dmd_pkg::RS_EXT_MEM2DEV) ||
                        (code[c] == dmd_pkg::RS_EXT_DEV2MEM);
            if (single[c]) begin
                raw_ack[c] = i_chan_busy[c] & (i_read_cycle | i_write_cycle);
            end else if (tim_ok[c] && s.ctl[c][dmd_pkg::BIT_ACK_TIM]) begin
                raw_ack[c] = i_chan_busy[c] & i_write_cycle;
            end else begin
                raw_ack[c] = i_chan_busy[c] & i_read_cycle;
            end
            next_s.ack[c] = raw_ack[c] ^ (pol_ok[c] & s.ctl[c][dmd_pkg::BIT_ACK_POL]);

            next_s.area6[c] = s.ctl[c][dmd_pkg::BIT_DEST_WAIT];
            next_s.dstep[c] = dmd_pkg::dmd_step(s.ctl[c][dmd_pkg::DM_HI:dmd_pkg::DM_LO],
                                                s.ctl[c][dmd_pkg::TS_HI:dmd_pkg::TS_LO],
                                                code[c] == dmd_pkg::RS_EXT_MEM2DEV);
            next_s.sstep[c] = dmd_pkg::dmd_step(s.ctl[c][dmd_pkg::SM_HI:dmd_pkg::SM_LO],
                                                s.ctl[c][dmd_pkg::TS_HI:dmd_pkg::TS_LO],
                                                code[c] == dmd_pkg::RS_EXT_DEV2MEM);
        end
    end

    // Control registers live on through low-power modes; only reset clears them.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
            // Synchronisers start at the idle pin level so no false request follows reset.
            s.sync1 <= '1;
            s.sync2 <= '1;
            s.prev <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign o_request = s.req;
    assign o_request_accepted_out = s.accepted;
    assign o_ack_out = s.ack;
    assign o_dest_wait_area6 = s.area6;
    assign o_burst_level = s.burst_level;
    assign o_burst_edge = s.burst_edge;
    assign o_dest_step = s.dstep;
    assign o_src_step = s.sstep;
    assign o_on_demand_mode = s.ondemand;

    default clocking dmd_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    chk_bus_answer_once: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest
    ) else $error("bus access not answered after one wait cycle");

    chk_reserved_read_zero: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address <= dmd_pkg::ADDR_CTL_LAST
        |-> o_avs_readdata[dmd_pkg::RSV_HI:dmd_pkg::RSV_LO] == 4'h0
    ) else $error("reserved control bits read nonzero");

    chk_pol_absent_hi: assert property (
        s.ctl[2][dmd_pkg::BIT_ACC_POL] == 1'b0 && s.ctl[3][dmd_pkg::BIT_ACK_POL] == 1'b0 &&
        s.ctl[3][dmd_pkg::BIT_ACC_POL] == 1'b0 && s.ctl[2][dmd_pkg::BIT_ACK_POL] == 1'b0
    ) else $error("polarity bit stored on channel 2 or 3");

    chk_dtr_load_inc: assert property (
        od && i_dtr_load |=> s.ctl[0][dmd_pkg::DM_HI:dmd_pkg::SM_LO] == 4'h5
    ) else $error("format load did not set increment modes");

    chk_ch2_no_ext: assert property (
        !od && dmd_pkg::dmd_is_ext(s.ctl[2][dmd_pkg::RS_HI:dmd_pkg::RS_LO]) |=> !o_request[2]
    ) else $error("channel 2 took an external request in normal mode");

    chk_level_request: assert property (
        !od && s.ctl[0][dmd_pkg::RS_HI:dmd_pkg::RS_LO] == dmd_pkg::RS_EXT_DUAL &&
        s.ctl[0][dmd_pkg::BIT_DE] && !s.ctl[0][dmd_pkg::BIT_TE] &&
        !s.ctl[0][dmd_pkg::BIT_SAMPLE] && !i_ext_request_pin_b[0] ##1
        $stable(s.ctl[0]) && $stable(od) && !i_ext_request_pin_b[0] ##1
        $stable(s.ctl[0]) && $stable(od) |=> o_request[0]
    ) else $error("low level on request pin not detected");

    chk_edge_once: assert property (
        o_request[0] && s.ctl[0][dmd_pkg::BIT_SAMPLE] && $past(s.ctl[0][dmd_pkg::BIT_SAMPLE])
        && dmd_pkg::dmd_is_ext(s.ctl[0][dmd_pkg::RS_HI:dmd_pkg::RS_LO]) && $stable(s.ctl[0])
        |-> !$past(o_request[0])
    ) else $error("edge request held longer than one cycle");

    chk_ack_single: assert property (
        !od && s.ctl[1][dmd_pkg::RS_HI:dmd_pkg::RS_LO] == dmd_pkg::RS_EXT_MEM2DEV &&
        !s.ctl[1][dmd_pkg::BIT_ACK_POL] && i_chan_busy[1] && i_write_cycle |=> o_ack_out[1]
    ) else $error("single-address acknowledge missing");

    chk_dest_ignored: assert property (
        s.ctl[0][dmd_pkg::RS_HI:dmd_pkg::RS_LO] == dmd_pkg::RS_EXT_MEM2DEV
        |=> o_dest_step[7:0] == 8'h00
    ) else $error("destination step not ignored for memory to device");

    chk_src_ignored: assert property (
        s.ctl[0][dmd_pkg::RS_HI:dmd_pkg::RS_LO] == dmd_pkg::RS_EXT_DEV2MEM
        |=> o_src_step[7:0] == 8'h00
    ) else $error("source step not ignored for device to memory");

    chk_area_select: assert property (
        $rose(s.ctl[3][dmd_pkg::BIT_DEST_WAIT]) |=> o_dest_wait_area6[3] ##1 o_dest_wait_area6[3]
        or $fell(s.ctl[3][dmd_pkg::BIT_DEST_WAIT])
    ) else $error("area wait select did not follow control bit");

    cov_write_read: cover property (
        i_avs_write && !o_avs_waitrequest ##1 i_avs_read ##1 i_avs_read && !o_avs_waitrequest
    );
    cov_edge_req: cover property (o_request[1] && o_burst_edge[1]);
    cov_dtr_load: cover property (od && i_dtr_load);
    cov_ack_low: cover property (s.ctl[0][dmd_pkg::BIT_ACK_POL] && !o_ack_out[0]);

endmodule : dmd_channel_decode

// *** verif/dmd_periph_model.sv ***
// Peripheral model that drives the active-low request pins.
`timescale 1ns/10ps
module dmd_periph_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_hold,
    output logic [3:0] o_ext_request_pin_b
);
    // A released pin idles high, so an idle peripheral never looks like a request.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ext_request_pin_b <= 4'hF;
        end else begin
            o_ext_request_pin_b <= ~i_hold;
        end
    end
endmodule : dmd_periph_model

// *** verif/dmd_channel_decode_test.sv ***
// Self-checking bench for the DMA channel mode decoder.
`timescale 1ns/10ps
module dmd_channel_decode_test;
    logic i_clk, i_rst_b, rd, wr, waitreq, rcyc, wcyc, dtr, odm;
    logic [7:0] addr, neg;
    logic [31:0] wd, rdata, dstep, sstep, q;
    logic [3:0] hold, pin_b, accept, busy, req, acc_o, ack_o, area6, blv, bed;
    logic [4:0] periph;
    logic [7:0] unit [5] = '{8'h08, 8'h01, 8'h02, 8'h04, 8'h20};
    logic [3:0] codes [10] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    logic [4:0] pmask [10] = '{5'h00, 5'h00, 5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10, 5'h10};
    int bad_count = 0;
    int total_checks = 0;
    int hits;

    dmd_channel_decode dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_ext_request_pin_b(pin_b),
        .i_serial1_tx_empty(periph[0]), .i_serial1_rx_full(periph[1]),
        .i_serial2_fifo_tx_empty(periph[2]), .i_serial2_fifo_rx_full(periph[3]),
        .i_timer2_capture(periph[4]), .i_accept(accept), .i_chan_busy(busy),
        .i_read_cycle(rcyc), .i_write_cycle(wcyc), .i_transfer_end(4'h0), .i_dtr_load(dtr),
        .o_request(req), .o_request_accepted_out(acc_o), .o_ack_out(ack_o),
        .o_dest_wait_area6(area6), .o_burst_level(blv), .o_burst_edge(bed),
        .o_dest_step(dstep), .o_src_step(sstep), .o_on_demand_mode(odm)
    );

    dmd_periph_model partner (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hold(hold), .o_ext_request_pin_b(pin_b)
    );

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic close_out;
        $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic see(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : see

    // Waitrequest is sampled mid-cycle so the edge that takes the access is never raced.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic stall;
        @(posedge i_clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(negedge i_clk);
            stall = waitreq;
            q = rdata;
            @(posedge i_clk);
        end while (stall !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wrc

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        see(q, exp);
    endtask : rdc

    task automatic settle;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask : settle

    task automatic pulses(input int ch, input logic [3:0] h, input int exp);
        hits = 0;
        @(posedge i_clk);
        hold <= h;
        repeat (12) begin
            @(negedge i_clk);
            hits += int'(req[ch] === 1'b1);
        end
        @(posedge i_clk);
        hold <= 4'h0;
        repeat (6) @(posedge i_clk);
        see(32'(hits), 32'(exp));
    endtask : pulses

    task automatic dtr_pulse;
        @(posedge i_clk);
        dtr <= 1'b1;
        @(posedge i_clk);
        dtr <= 1'b0;
        bus(1'b0, 8'h00, 32'h0);
    endtask : dtr_pulse

    // The whole sequence needs a few hundred cycles; this bound leaves a wide margin.
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        close_out;
    end

    initial begin
        i_rst_b = 1'b0;
        {addr, rd, wr, wd, hold, periph, accept, busy, rcyc, wcyc, dtr} = '0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int c = 0; c < 5; c++) rdc(8'(4 * c), 32'h0);
        $display("Reset test done");
        wrc(8'h00, 32'hFF0F_5BC7);
        rdc(8'h00, 32'hFF0F_5BC5);
        wrc(8'h08, 32'hFF0F_5BC7);
        rdc(8'h08, 32'hFF0A_5BC5);
        wrc(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0);
        wrc(8'h08, 32'h0);
        $display("Register access test done");
        for (int i = 0; i < 5; i++) begin
            wrc(8'h04, {16'h0, 8'h64, 1'b0, 3'(i), 4'h0});
            settle;
            neg = 8'h00 - unit[i];
            see(32'({dstep[15:8], sstep[15:8]}), 32'({unit[i], neg}));
        end
        wrc(8'h04, 32'h0000_0010);
        settle;
        see(32'({dstep[15:8], sstep[15:8]}), 32'h0);
        wrc(8'h00, 32'h0000_5210);
        settle;
        see(32'({dstep[7:0], sstep[7:0]}), 32'h0001);
        wrc(8'h00, 32'h0000_5310);
        settle;
        see(32'({dstep[7:0], sstep[7:0]}), 32'h0100);
        $display("Address step test done");
        wrc(8'h0C, 32'h0100_0400);
        wrc(8'h00, 32'h0000_0080);
        settle;
        see(32'({area6, blv, bed}), 32'h810);
        wrc(8'h00, 32'h0008_0080);
        settle;
        see(32'({blv, bed}), 32'h01);
        $display("Wait area and burst test done");
        wrc(8'h00, 32'h0000_0001);
        wrc(8'h08, 32'h0000_0001);
        @(posedge i_clk);
        hold <= 4'h5;
        @(posedge i_clk);
        @(negedge i_clk);
        see(32'(req), 32'h0);
        repeat (6) @(negedge i_clk);
        see(32'(req), 32'h1);
        @(posedge i_clk);
        hold <= 4'h0;
        repeat (6) @(negedge i_clk);
        see(32'(req), 32'h0);
        wrc(8'h00, 32'h0008_0001);
        pulses(0, 4'h1, 1);
        wrc(8'h10, 32'h1);
        wrc(8'h08, 32'h0008_0001);
        pulses(2, 4'h4, 1);
        wrc(8'h10, 32'h0);
        wrc(8'h00, 32'h0);
        $display("External request test done");
        for (int i = 0; i < 10; i++) begin
            wrc(8'h0C, {20'h0, codes[i], 8'h01});
            @(posedge i_clk);
            periph <= ~pmask[i];
            settle;
            see(32'(req[3]), 32'(pmask[i] == 5'h00));
            @(posedge i_clk);
            periph <= pmask[i];
            settle;
            see(32'(req[3]), 32'h1);
        end
        wrc(8'h0C, 32'h0);
        $display("Request source test done");
        wrc(8'h00, 32'h0005_0000);
        wrc(8'h04, 32'h0002_0000);
        wrc(8'h08, 32'h0007_0000);
        @(posedge i_clk);
        accept <= 4'h5;
        busy <= 4'h7;
        rcyc <= 1'b1;
        settle;
        see(32'({acc_o[2], acc_o[0], ack_o[2:0]}), 32'h14);
        @(posedge i_clk);
        rcyc <= 1'b0;
        wcyc <= 1'b1;
        settle;
        see(32'(ack_o[2:0]), 32'h3);
        wrc(8'h04, 32'h0002_0200);
        @(posedge i_clk);
        rcyc <= 1'b1;
        wcyc <= 1'b0;
        wrc(8'h10, 32'h1);
        settle;
        see(32'({acc_o[0], ack_o[2:0]}), 32'hB);
        $display("Accept and acknowledge test done");
        wrc(8'h10, 32'h0);
        wrc(8'h00, 32'h0000_A000);
        dtr_pulse;
        see(32'(q[15:12]), 32'hA);
        wrc(8'h10, 32'h1);
        dtr_pulse;
        see(32'(q[15:12]), 32'h5);
        see(32'(odm), 32'h1);
        $display("Format load test done");
        close_out;
    end
endmodule : dmd_channel_decode_test
